/* rtl/paired_float_branch_compare_convert.sv */
// branch on four flags, magnitude compare and paired conversions
// Operation
// - decode four-flag branch, sense one, nullify zero
// - take branch if any of four flags set
// - target is delay-slot address plus shifted displacement
// - redirect only after the delay slot executes
// - compare magnitudes exactly, no overflow or underflow
// - compare writes outcome into addressed flag
// - outcome ORs less, equal, unordered by predicate
// - nan means unordered; invalid on signalling or bit3
// - paired compare: lower to n, upper n+1
// - paired compare ORs both halves' exceptions
// - decode paired single to paired word
// - each half rounds to 32-bit integer
// - infinity, nan or range overflow flags invalid
// - trap leaves destination; else write maximum integer
// - decode paired word to paired single
// - each word rounds to single, upper stays upper
`timescale 1ns/100ps
module paired_float_branch_compare_convert
    import fpx_pkg::*;
(
    input  wire logic                  core_clk,       // core clock
    input  wire logic                  srst,           // synchronous reset
    input  wire logic                  issue_valid,    // instruction offered this cycle
    input  wire logic [31:0]           instr,          // instruction word
    input  wire logic [ADDR_WIDTH-1:0] slot_pc,        // address of the delay slot
    input  wire logic                  slot_done,      // delay slot instruction retired
    input  wire logic [FLAG_COUNT-1:0] cond_flags,     // current condition flags
    input  wire logic [63:0]           first_source,   // first_source_reg contents
    input  wire logic [63:0]           second_source,  // second_source_reg contents
    input  wire logic [1:0]            round_mode,     // rounding mode field
    input  wire logic                  invalid_enable, // invalid operation enable
    output logic                       branch_pending, // branch waits on its slot
    output logic                       redirect,       // pulse: load redirect_pc
    output logic [ADDR_WIDTH-1:0]      redirect_pc,    // branch target
    output flag_write_t                flag_write,     // condition flag update
    output fpr_write_t                 fpr_write,      // float_register update
    output logic                       invalid_set,    // pulse: set invalid flag
    output logic                       invalid_trap    // pulse: take the trap
);
    // every flop of the block lives in this one record
    typedef struct packed {
        br_state_t             fsm;
        logic                  taken;
        logic                  redirect;
        logic [ADDR_WIDTH-1:0] target;
        flag_write_t           flags;
        fpr_write_t            float_register;
        logic                  inv_set;
        logic                  trap;
    } state_t;

    localparam state_t RESET_STATE = '{fsm: st_idle, default: '0};

    state_t cur;        // registered state
    state_t next_cur;   // next state

    // instruction fields
    logic [5:0]  op;           // major opcode
    logic [4:0]  fmt;          // format or sub-opcode
    logic [4:0]  tgt_field;    // second source field
    logic [5:0]  funct;        // function code
    logic [2:0]  flag_index;   // flag_index field of the branch
    logic [2:0]  cmp_index;    // flag_index field of the compare
    logic [3:0]  pred;         // compare predicate
    logic [4:0]  destination_reg;
    logic [DISP_WIDTH-1:0] disp;

    assign op              = instr[31:26];
    assign fmt             = instr[25:21];
    assign tgt_field       = instr[20:16];
    assign funct           = instr[5:0];
    assign flag_index      = instr[20:18];
    assign cmp_index       = instr[10:8];
    assign pred            = instr[3:0];
    assign destination_reg = instr[10:6];
    assign disp            = instr[15:0];

    // decode strobes
    logic dec_branch;    // four-flag branch, true sense
    logic dec_cmp;       // magnitude_compare
    logic dec_ps2pw;     // pair_float_to_pair_int
    logic dec_pw2ps;     // pair_int_to_pair_float
    logic cmp_paired;    // compare in paired_single format
    logic cmp_double;    // compare in double format

    always_comb begin
        dec_branch = issue_valid && op == float_unit_major_opcode
                     && fmt == BRANCH_ANY4_SUB
                     && !instr[17] && instr[16];
        cmp_paired = fmt == FMT_PAIRED_SGL;
        cmp_double = fmt == FMT_DOUBLE;
        dec_cmp    = issue_valid && op == float_unit_major_opcode
                     && (fmt == FMT_SINGLE || cmp_double || cmp_paired)
                     && funct[5:4] == FN_COMPARE_TOP
                     && instr[7:6] == CMP_ABS_MARK;
        dec_ps2pw  = issue_valid && op == float_unit_major_opcode
                     && fmt == FMT_PAIRED_SGL && tgt_field == 5'h0
                     && funct == FN_PS_TO_PW;
        dec_pw2ps  = issue_valid && op == float_unit_major_opcode
                     && fmt == FMT_PAIRED_WORD && tgt_field == 5'h0
                     && funct == FN_PW_TO_PS;
    end

    // magnitude compare of one operand pair: {snan, unordered, less, equal}
    // sign bits are dropped, so raw unsigned order of the rest is exact
    function automatic logic [3:0] mag_cmp(input logic [63:0] a,
                                           input logic [63:0] b,
                                           input logic dbl);
        logic [62:0] ma;
        logic [62:0] mb;
        logic        na;
        logic        nb;
        logic        sa;
        logic        sb;
        ma = dbl ? a[62:0] : {32'h0, a[30:0]};
        mb = dbl ? b[62:0] : {32'h0, b[30:0]};
        na = dbl ? (&a[62:52] && |a[51:0]) : (&a[30:23] && |a[22:0]);
        nb = dbl ? (&b[62:52] && |b[51:0]) : (&b[30:23] && |b[22:0]);
        sa = na && !(dbl ? a[51] : a[22]);
        sb = nb && !(dbl ? b[51] : b[22]);
        return {sa | sb, na | nb, !(na | nb) && ma < mb,
                !(na | nb) && ma == mb};
    endfunction : mag_cmp

    // signed word to single precision with the current rounding mode
    function automatic logic [31:0] word_to_single(input logic [31:0] w,
                                                   input logic [1:0] rm);
        logic        s;
        logic [31:0] mag;
        logic [31:0] n;
        logic [4:0]  p;
        logic        inc;
        logic [24:0] m;
        logic [7:0]  e;
        s   = w[31];
        mag = s ? 32'(32'h0 - w) : w;
        p   = '0;
        for (int i = 0; i < 32; i++) begin
            if (mag[i]) begin
                p = 5'(i);
            end
        end
        n   = mag << (5'd31 - p);
        inc = round_inc(rm, s, n[8], n[7], |n[6:0]);
        m   = {1'b1, n[30:8]} + {24'h0, inc};
        e   = SGL_BIAS + {3'h0, p} + {7'h0, m[24]};
        if (mag == 32'h0) begin
            return 32'h0;
        end
        return {s, e, m[24] ? m[23:1] : m[22:0]};
    endfunction : word_to_single

    // compare results, one per half; half 0 also serves single and double
    logic [3:0] cmp_res [2];   // {snan, unordered, less, equal}
    logic [1:0] cmp_out;       // predicate outcome per half
    logic [1:0] cmp_inv;       // invalid per half
    // paired-word conversion results per half
    logic [31:0] cvt_word [2];
    logic [1:0]  cvt_inv;
    logic [31:0] cvt_sgl [2];

    // both halves share one structure, so one loop builds them
    for (genvar h = 0; h < 2; h++) begin : g_half
        always_comb begin
            cmp_res[h] = mag_cmp(h == 0 ? first_source
                                        : {32'h0, first_source[63:32]},
                                 h == 0 ? second_source
                                        : {32'h0, second_source[63:32]},
                                 h == 0 && cmp_double);
            cmp_out[h] = (pred[2] & cmp_res[h][1])
                       | (pred[1] & cmp_res[h][0])
                       | (pred[0] & cmp_res[h][2]);
            cmp_inv[h] = cmp_res[h][3] | (pred[3] & cmp_res[h][2]);
            cvt_sgl[h] = word_to_single(first_source[32*h +: 32],
                                        round_mode);
        end
        single_to_word single_to_word_inst (
            .value      (first_source[32*h +: 32]),
            .round_mode (round_mode),
            .result     (cvt_word[h]),
            .invalid    (cvt_inv[h])
        );
    end

    logic       cmp_any_inv;   // combined compare exception
    logic [2:0] pair_base;     // even flag index for paired compare
    logic       any4;          // any of the four selected flags set

    always_comb begin
        cmp_any_inv = cmp_inv[0] | (cmp_paired & cmp_inv[1]);
        pair_base   = {cmp_index[2:1], 1'b0};
        // misaligned index bits are ignored, the issuer keeps them clear
        any4 = flag_index[2] ? |cond_flags[7:4] : |cond_flags[3:0];
    end

    // next state: pulses fall back each cycle, branch fsm advances
    always_comb begin
        next_cur          = cur;
        next_cur.redirect = 1'b0;
        next_cur.flags    = '0;
        next_cur.float_register.we   = 1'b0;
        next_cur.inv_set  = 1'b0;
        next_cur.trap     = 1'b0;
        unique case (cur.fsm)
            st_idle: begin
                // a branch inside a delay slot is not accepted here
                if (dec_branch) begin
                    next_cur.fsm    = st_slot;
                    next_cur.taken  = any4;
                    next_cur.target = slot_pc
                        + {{(ADDR_WIDTH-DISP_WIDTH-2){disp[15]}}, disp, 2'b00};
                end
            end
            st_slot: begin
                // wait for the delay slot before steering the fetch
                if (slot_done) begin
                    next_cur.fsm      = st_idle;
                    next_cur.redirect = cur.taken;
                end
            end
        endcase
        if (dec_cmp) begin
            next_cur.inv_set = cmp_any_inv;
            if (cmp_any_inv && invalid_enable) begin
                next_cur.trap = 1'b1;
            end else if (cmp_paired) begin
                next_cur.flags.we  = 8'(8'h3 << pair_base);
                next_cur.flags.val = 8'({6'h0, cmp_out} << pair_base);
            end else begin
                next_cur.flags.we  = 8'(8'h1 << cmp_index);
                next_cur.flags.val = 8'({7'h0, cmp_out[0]} << cmp_index);
            end
        end
        if (dec_ps2pw) begin
            next_cur.inv_set = |cvt_inv;
            next_cur.float_register.addr = destination_reg;
            if (|cvt_inv && invalid_enable) begin
                next_cur.trap = 1'b1;
            end else begin
                // a good half keeps its value beside a defaulted one
                next_cur.float_register.we   = 1'b1;
                next_cur.float_register.data = {cvt_word[1], cvt_word[0]};
            end
        end
        if (dec_pw2ps) begin
            next_cur.float_register.we   = 1'b1;
            next_cur.float_register.addr = destination_reg;
            next_cur.float_register.data = {cvt_sgl[1], cvt_sgl[0]};
        end
    end

    // one register bank for the whole record
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cur <= RESET_STATE;
        end else begin
            cur <= next_cur;
        end
    end

    assign branch_pending = cur.fsm == st_slot;
    assign redirect       = cur.redirect;
    assign redirect_pc    = cur.target;
    assign flag_write     = cur.flags;
    assign fpr_write      = cur.float_register;
    assign invalid_set    = cur.inv_set;
    assign invalid_trap   = cur.trap;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_branch_accept;
        !branch_pending && dec_branch |=> branch_pending;
    endproperty
    a_branch_accept: assert property (p_branch_accept)
        else $error("four-flag branch not accepted");

    property p_taken_any;
        !branch_pending && dec_branch && (|cond_flags[3:0])
            && !flag_index[2] ##1 slot_done |=> redirect;
    endproperty
    a_taken_any: assert property (p_taken_any)
        else $error("branch not taken with a flag set");

    property p_target;
        !branch_pending && dec_branch ##1 slot_done |=>
            redirect_pc == $past(slot_pc, 2)
                + {{46{$past(instr[15], 2)}}, $past(instr[15:0], 2), 2'b00};
    endproperty
    a_target: assert property (p_target)
        else $error("branch target wrong");

    property p_wait_slot;
        branch_pending && !slot_done |=> !redirect && branch_pending;
    endproperty
    a_wait_slot: assert property (p_wait_slot)
        else $error("redirect before the delay slot retired");

    property p_cmp_single;
        dec_cmp && !cmp_paired && !(cmp_any_inv && invalid_enable) |=>
            flag_write.we == 8'(8'h1 << $past(cmp_index))
            && flag_write.val[$past(cmp_index)] == $past(cmp_out[0]);
    endproperty
    a_cmp_single: assert property (p_cmp_single)
        else $error("compare flag write wrong");

    property p_nan_unordered;
        dec_cmp && !cmp_paired && pred == 4'h9 && &first_source[30:22]
            && !cmp_double && !invalid_enable |=>
            invalid_set && flag_write.val[$past(cmp_index)];
    endproperty
    a_nan_unordered: assert property (p_nan_unordered)
        else $error("quiet nan not unordered or not invalid");

    property p_cmp_paired;
        dec_cmp && cmp_paired && !(cmp_any_inv && invalid_enable) |=>
            $countones(flag_write.we) == 2
            && flag_write.we[$past(cmp_index) & 3'h6]
            && flag_write.we[($past(cmp_index) & 3'h6) + 3'h1];
    endproperty
    a_cmp_paired: assert property (p_cmp_paired)
        else $error("paired compare flags wrong");

    property p_cmp_or;
        dec_cmp && cmp_paired && (cmp_inv[1] || cmp_inv[0]) |=> invalid_set;
    endproperty
    a_cmp_or: assert property (p_cmp_or)
        else $error("half exception lost");

    property p_cvt_inf_trap;
        dec_ps2pw && first_source[62:55] == 8'hff && invalid_enable |=>
            invalid_set && invalid_trap && !fpr_write.we;
    endproperty
    a_cvt_inf_trap: assert property (p_cvt_inf_trap)
        else $error("trap not taken or destination written");

    property p_cvt_default;
        dec_ps2pw && first_source[30:23] == 8'hff && !invalid_enable |=>
            fpr_write.we && fpr_write.data[31:0] == WORD_MAX && invalid_set;
    endproperty
    a_cvt_default: assert property (p_cvt_default)
        else $error("default integer not written");

    property p_pw2ps;
        dec_pw2ps && first_source == 64'h0000000100000000 |=>
            fpr_write.we && fpr_write.data == 64'h3f80000000000000;
    endproperty
    a_pw2ps: assert property (p_pw2ps)
        else $error("paired word conversion wrong");
endmodule : paired_float_branch_compare_convert

/* rtl/fpx_pkg.sv */
// shared constants, types and helpers of the paired float execution block
package fpx_pkg;
    // instruction fields
    localparam logic [5:0] float_unit_major_opcode = 6'h11;  // 010001
    localparam logic [4:0] BRANCH_ANY4_SUB  = 5'h0a;         // 01010
    localparam logic [4:0] FMT_SINGLE       = 5'h10;
    localparam logic [4:0] FMT_DOUBLE       = 5'h11;
    localparam logic [4:0] FMT_PAIRED_WORD  = 5'h14;         // 10100
    localparam logic [4:0] FMT_PAIRED_SGL   = 5'h16;         // 10110
    localparam logic [5:0] FN_PS_TO_PW      = 6'h24;         // 100100
    localparam logic [5:0] FN_PW_TO_PS      = 6'h26;         // 100110
    localparam logic [1:0] FN_COMPARE_TOP   = 2'h3;          // funct[5:4]
    localparam logic [1:0] CMP_ABS_MARK     = 2'h1;          // instr[7:6]
    localparam int         DISP_WIDTH       = 16;
    localparam int         ADDR_WIDTH       = 64;
    localparam int         FLAG_COUNT       = 8;
    // rounding modes as held in the control/status register
    localparam logic [1:0] RM_NEAREST = 2'h0;
    localparam logic [1:0] RM_ZERO    = 2'h1;
    localparam logic [1:0] RM_PLUS    = 2'h2;
    localparam logic [1:0] RM_MINUS   = 2'h3;
    localparam logic [31:0] WORD_MAX  = 32'h7fffffff;       // invalid default
    localparam logic [7:0]  SGL_BIAS  = 8'h7f;

    typedef enum logic [0:0] {
        st_idle = 1'b0,   // no branch pending
        st_slot = 1'b1    // branch decided, delay slot running
    } br_state_t;

    // condition flag write port
    typedef struct packed {
        logic [7:0] we;
        logic [7:0] val;
    } flag_write_t;

    // float register write port
    typedef struct packed {
        logic        we;
        logic [4:0]  addr;
        logic [63:0] data;
    } fpr_write_t;

    // increment decision for a truncated magnitude
    function automatic logic round_inc(input logic [1:0] rm, input logic sgn,
                                       input logic lsb, input logic grd,
                                       input logic stk);
        unique case (rm)
            RM_NEAREST: return grd & (stk | lsb);
            RM_ZERO:    return 1'b0;
            RM_PLUS:    return ~sgn & (grd | stk);
            RM_MINUS:   return sgn & (grd | stk);
        endcase
    endfunction : round_inc
endpackage : fpx_pkg

/* rtl/single_to_word.sv */
// one single precision value to a signed 32-bit integer, with rounding
`timescale 1ns/100ps
module single_to_word
    import fpx_pkg::*;
(
    input  wire logic [31:0] value,       // single precision source half
    input  wire logic [1:0]  round_mode,  // current rounding mode
    output logic      [31:0] result,      // integer, or the default on invalid
    output logic             invalid      // infinity, nan or out of range
);
    logic        sgn;          // source sign
    logic [7:0]  expo;         // biased exponent
    logic [23:0] sig;          // significand with hidden bit
    logic [55:0] fixed;        // binary point between bits 24 and 23
    logic [31:0] ipart;        // truncated integer part
    logic        grd;          // first dropped bit
    logic        stk;          // any later dropped bit
    logic [32:0] mag;          // rounded magnitude, one spare bit

    // align, round, then range check; all combinational
    always_comb begin
        sgn   = value[31];
        expo  = value[30:23];
        sig   = {|expo, value[22:0]};
        fixed = '0;
        ipart = '0;
        grd   = 1'b0;
        stk   = 1'b0;
        if (expo < 8'd126) begin
            // below one half: only the sticky bit survives
            stk = |value[30:0];
        end else if (expo <= 8'd158) begin
            fixed = {sig, 32'h0} >> (8'd158 - expo);
            ipart = fixed[55:24];
            grd   = fixed[23];
            stk   = |fixed[22:0];
        end
        mag = {1'b0, ipart} + {32'h0, round_inc(round_mode, sgn, ipart[0], grd, stk)};
        // minus two to the 31st is the one magnitude legal only when negative
        if (expo == 8'hff || expo > 8'd158) begin
            invalid = 1'b1;
        end else if (sgn) begin
            invalid = mag > 33'h080000000;
        end else begin
            invalid = mag > 33'h07fffffff;
        end
        if (invalid) begin
            result = WORD_MAX;
        end else if (sgn) begin
            result = 32'(33'h0 - mag);
        end else begin
            result = mag[31:0];
        end
    end
endmodule : single_to_word

/* sim/slot_retire_model.sv */
// pipeline model that retires the delay slot of a pending branch
`timescale 1ns/100ps
module slot_retire_model (
    input  wire logic       core_clk,       // core clock
    input  wire logic       srst,           // synchronous reset
    input  wire logic       branch_pending, // branch waits on its slot
    input  wire logic [3:0] slot_delay,     // extra cycles the slot takes
    output logic            slot_done       // pulse: delay slot retired
);
    logic [3:0] cnt; // cycles spent on the slot so far

    // quiet before the first edge, so the block never sees an unknown
    initial slot_done = 1'h0;

    // count while the branch waits, then one retire pulse; a slow slot
    // shows whether the block jumps early
    always @(posedge core_clk) begin
        if (srst || !branch_pending) begin
            cnt       <= 4'h0;
            slot_done <= 1'h0;
        end else begin
            cnt       <= cnt + 4'h1;
            slot_done <= (cnt == slot_delay);
        end
    end
endmodule : slot_retire_model

/* sim/paired_float_branch_compare_convert_bench.sv */
// self-checking bench of the paired float execution block
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module paired_float_branch_compare_convert_bench
    import fpx_pkg::*;
;
    logic        core_clk = 1'h0, srst = 1'h1, issue_valid = 1'h0, invalid_enable = 1'h0;
    logic [31:0] instr = 32'h0;           // instruction offered
    logic [63:0] slot_pc = 64'h401000;    // delay slot address
    logic [63:0] first_source = 64'h0, second_source = 64'h0, redirect_pc;
    logic [7:0]  cond_flags = 8'h0;       // condition flags seen by branches
    logic [1:0]  round_mode = 2'h0;       // current rounding mode
    logic [3:0]  slot_delay = 4'h0;       // how slowly the slot retires
    logic        slot_done, branch_pending, redirect, invalid_set, invalid_trap;
    flag_write_t flag_write;              // flag update from compares
    fpr_write_t  fpr_write;               // register update from conversions
    int          errors = 0, n_tests = 0; // mismatch and comparison counts

    always #2 core_clk = ~core_clk;

    paired_float_branch_compare_convert paired_float_branch_compare_convert_inst (
        .core_clk(core_clk), .srst(srst), .issue_valid(issue_valid), .instr(instr),
        .slot_pc(slot_pc), .slot_done(slot_done), .cond_flags(cond_flags),
        .first_source(first_source), .second_source(second_source),
        .round_mode(round_mode), .invalid_enable(invalid_enable),
        .branch_pending(branch_pending), .redirect(redirect), .redirect_pc(redirect_pc),
        .flag_write(flag_write), .fpr_write(fpr_write), .invalid_set(invalid_set),
        .invalid_trap(invalid_trap));
    slot_retire_model slot_retire_model_inst (
        .core_clk(core_clk), .srst(srst), .branch_pending(branch_pending),
        .slot_delay(slot_delay), .slot_done(slot_done));

    // one issue cycle; an idle cycle first keeps valid from toggling twice
    task automatic issue(input logic [31:0] word);
        @(posedge core_clk); #1;
        instr = word;
        issue_valid = 1'h1;
        @(posedge core_clk); #1;
        issue_valid = 1'h0;
    endtask : issue

    // four-flag branch; redirect must wait for the slot, then pulse once
    task automatic branch(input logic [2:0] idx, input logic [15:0] disp,
                          input logic taken, input logic [3:0] dly);
        int n;
        n = 0;
        slot_delay = dly;
        issue({float_unit_major_opcode, BRANCH_ANY4_SUB, idx, 2'h1, disp});
        while (branch_pending === 1'h1 && redirect !== 1'h1 && n < 20) begin
            @(posedge core_clk); #1;
            n++;
        end
        `CHK(n, int'(dly) + 2)
        `CHK(redirect, taken)
        if (taken) `CHK(redirect_pc, slot_pc + {{46{disp[15]}}, disp, 2'h0})
        @(posedge core_clk); #1;
        `CHK(redirect, 1'h0)
    endtask : branch

    // magnitude compare; a trap suppresses the flag write
    task automatic compare(input logic [4:0] fmt, input logic [2:0] idx,
                           input logic [3:0] pred, input logic [63:0] a, b,
                           input logic [7:0] we, val, input logic inv);
        logic [7:0] we_e;
        first_source = a;
        second_source = b;
        we_e = (inv & invalid_enable) ? 8'h0 : we;
        issue({float_unit_major_opcode, fmt, 10'h0, idx, CMP_ABS_MARK, FN_COMPARE_TOP, pred});
        `CHK(flag_write.we, we_e)
        `CHK(flag_write.val & we_e, val & we_e)
        `CHK(invalid_trap, inv & invalid_enable)
        if (!invalid_enable) `CHK(invalid_set, inv)
    endtask : compare

    // paired conversion into register 7
    task automatic convert(input logic [5:0] fn, input logic [63:0] src, exp,
                           input logic inv);
        logic we_e;
        first_source = src;
        we_e = !(inv & invalid_enable);
        issue({float_unit_major_opcode, fn == FN_PS_TO_PW ? FMT_PAIRED_SGL : FMT_PAIRED_WORD,
               10'h0, 5'h07, fn});
        `CHK(fpr_write.we, we_e)
        if (we_e) `CHK(fpr_write.addr, 5'h07)
        if (we_e) `CHK(fpr_write.data, exp)
        `CHK(invalid_trap, inv & invalid_enable)
        if (!invalid_enable) `CHK(invalid_set, inv)
    endtask : convert

    // counts, verdict and end of run
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    // a hang is cut short long after the fewer than a hundred cycles needed
    initial begin
        #20000;
        errors++;
        end_of_test();
    end

    // main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        #1;
        srst = 1'h0;
        `CHK(branch_pending, 1'h0)
        cond_flags = 8'h40;
        branch(3'h4, 16'hfff0, 1'h1, 4'h0);
        branch(3'h0, 16'h0010, 1'h0, 4'h3);
        cond_flags = 8'h01;
        branch(3'h0, 16'h7fff, 1'h1, 4'h5);
        for (int e = 0; e < 2; e++) begin
            invalid_enable = e[0];
            compare(FMT_SINGLE, 3'h3, 4'h2, {2{32'hc0000000}}, {2{32'h40000000}},
                    8'h08, 8'h08, 1'h0);
            compare(FMT_SINGLE, 3'h3, 4'h4, {2{32'hc0000000}}, {2{32'h40000000}},
                    8'h08, 8'h00, 1'h0);
            compare(FMT_DOUBLE, 3'h1, 4'h4, 64'h3ff0000000000000, 64'hc000000000000000,
                    8'h02, 8'h02, 1'h0);
            compare(FMT_SINGLE, 3'h0, 4'h1, {2{32'h7f800001}}, 64'h0, 8'h01, 8'h01, 1'h1);
            compare(FMT_SINGLE, 3'h2, 4'h9, {2{32'h7fc00000}}, 64'h0, 8'h04, 8'h04, 1'h1);
            compare(FMT_PAIRED_SGL, 3'h4, 4'ha, 64'h7fc00000_3f800000, 64'hbf800000,
                    8'h30, 8'h10, 1'h1);
        end
        convert(FN_PS_TO_PW, 64'h7f800000_c0200000, 64'h0, 1'h1);
        invalid_enable = 1'h0;
        for (int r = 0; r < 4; r++) begin
            round_mode = r[1:0];
            convert(FN_PS_TO_PW, 64'hc0200000_7f800000,
                    {r == 3 ? 32'hfffffffd : 32'hfffffffe, WORD_MAX}, 1'h1);
            convert(FN_PW_TO_PS, 64'h00000003_01000001,
                    {32'h40400000, r == 2 ? 32'h4b800001 : 32'h4b800000}, 1'h0);
        end
        round_mode = RM_NEAREST;
        convert(FN_PW_TO_PS, 64'h00000001_00000000, 64'h3f800000_00000000, 1'h0);
        convert(FN_PS_TO_PW, 64'h4f000000_cf000000, {WORD_MAX, 32'h80000000}, 1'h1);
        end_of_test();
    end
endmodule : paired_float_branch_compare_convert_bench
